// *** hw/ext_bus_pkg.sv ***
package ext_bus_pkg;
    // =====================================================
    // Timing
    // =====================================================
    localparam int unsigned CORE_CLK_HZ       = 50_000_000; // Core clock rate
    localparam int unsigned SLOT_PERIODS      = 6;          // Oscillator periods per strobe slot
    localparam int unsigned STRONG_PU_PERIODS = 2;          // Strong pull-up span after 0-to-1
    localparam logic [2:0]  SLOT_LAST         = 3'(SLOT_PERIODS - 1);
    localparam logic [1:0]  STRONG_PU_LOAD    = 2'(STRONG_PU_PERIODS);
    // Phase positions inside one six-period slot
    localparam logic [2:0]  PH_ADDR           = 3'h0;       // Address out, latch strobe high
    localparam logic [2:0]  PH_ALE_END        = 3'h1;       // Latch strobe falls after this
    localparam logic [2:0]  PH_STB_START      = 3'h2;       // Memory strobe asserted from here
    localparam logic [2:0]  PH_STB_END        = 3'h4;       // Memory strobe removed after this
    // =====================================================
    // Reset values and fields
    // =====================================================
    localparam int unsigned PWR_ALE_OFF_BIT   = 4;          // Bit of power control that disables latch strobe
    localparam logic [15:0] INT_CODE_TOP      = 16'h1FFF;   // Top of internal code space
    localparam logic [3:0]  P3_UPPER_RESET    = 4'hF;       // Port latches reset to ones
    localparam logic [7:0]  P2_RESET          = 8'hFF;

    typedef enum logic [1:0] {CYC_FETCH, CYC_READ, CYC_WRITE} cyc_e;

    // Access request from the core
    typedef struct packed {
        logic        valid;  // Access pending
        cyc_e        kind;   // Fetch, data read or data write
        logic [23:0] addr;   // Code uses low 16 bits
        logic [7:0]  wdata;  // Byte for a data write
        logic        wide;   // 24-bit data space access
    } req_s;
endpackage

// *** hw/external_memory_bus_port.sv ***
`timescale 1ns/1ps
// Behaviour
// RQ1: Upper port3 ones held by weak pull-up
// RQ2: Strong pull-up two clocks on rising output
// RQ3: Write strobe low during external data write
// RQ4: Read strobe low during external data read
// RQ5: Port2 ones weakly pulled, readable as inputs
// RQ6: Port2 carries A8-A15 on code fetch
// RQ7: Port2 carries A8-A23 on wide data
// RQ8: Code select high: low 8K internal
// RQ9: Code select latched only at reset release
// RQ10: Outside keeps code select steady
// RQ11: Program strobe each slot, not on data
// RQ12: Program strobe high during internal execution
// RQ13: Program strobe low at reset: download mode
// RQ14: Latch strobe marks low and page byte
// RQ15: Latch strobe each six periods, skipped on data
// RQ16: Power control bit 4 disables latch strobe
// RQ17: Serial clock weak pull-up unless driving low
// RQ18: Port0 multiplexes address then data, strong ones
// RQ19: Address and latch before strobe, strobe removed
module external_memory_bus_port
    import ext_bus_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire req_s        req,                 // Access request from core
    output logic             req_ready,           // Request taken this cycle
    output logic [7:0]       rdata,               // Captured read byte
    output logic             rdata_valid,         // One-cycle pulse with rdata
    input  wire logic [7:0]  power_control_register, // Bit 4 disables latch strobe
    input  wire logic [3:0]  p3_latch,            // Software port3 upper latches
    input  wire logic [7:0]  p2_latch,            // Software port2 latches
    input  wire logic [3:0]  port3_upper_pins_in, // Pin levels
    output logic [3:0]       port3_upper_pins_out,
    output logic [3:0]       port3_upper_pins_oe, // Active drive (low or strong high)
    output logic [3:0]       port3_weak_pu,       // Weak pull-up enable
    output logic             timer0_count_input,
    output logic             timer1_count_input,
    output logic [3:0]       port2_lower_pins_out,
    output logic [3:0]       port2_upper_pins_out,
    output logic [7:0]       port2_oe,
    output logic [7:0]       port2_weak_pu,
    input  wire logic [7:0]  port2_in,
    output logic [7:0]       port0_out,
    output logic [7:0]       port0_oe,
    input  wire logic [7:0]  port0_in,
    output logic             ale,                 // Address latch strobe, high active
    output logic             program_store_strobe_n,
    output logic             program_store_strobe_oe,
    input  wire logic        program_store_strobe_in,
    input  wire logic        external_code_select,
    output logic             external_code_mode,  // Latched mode, 1 = all external
    output logic             serial_download,     // Download strap caught at reset
    input  wire logic        sclk_drive_low,      // Serial block pulls clock low
    output logic             sclk_oe,
    output logic             sclk_weak_pu
);
    // =====================================================
    // State
    // =====================================================
    typedef struct packed {
        logic [2:0]  phase;     // Slot phase counter
        logic        active;    // Access in flight
        req_s        cur;       // Current access
        logic [3:0]  p3_prev;   // Previous port3 latch
        logic [7:0]  p3_strong; // Four strong-pull-up counters, two bits each
        logic        first;     // First cycle after reset release
        logic        ext_mode;
        logic        dl_mode;
        logic [7:0]  rd;
        logic        rd_v;
    } st_s;

    st_s st_reg, st_next;
    logic fetch_int;  // Fetch served internally

    // Internal fetch when mode internal and address in low 8K
    assign fetch_int = !st_reg.ext_mode && (req.addr[15:0] <= INT_CODE_TOP); // [RQ8]
    assign req_ready = req.valid && (fetch_int && req.kind == CYC_FETCH
                       || !st_reg.active && st_reg.phase == SLOT_LAST);

    // =====================================================
    // Next state
    // =====================================================
    always_comb begin
        st_next = st_reg;
        st_next.rd_v = 1'b0;
        st_next.first = 1'b0;
        // Straps sampled once, right after reset release
        if (st_reg.first) begin
            st_next.ext_mode = !external_code_select;   // [RQ9]
            st_next.dl_mode  = !program_store_strobe_in; // [RQ13]
        end
        st_next.phase = (st_reg.phase == SLOT_LAST) ? 3'h0 : st_reg.phase + 3'h1;
        // New access starts only at a slot boundary
        if (st_reg.phase == SLOT_LAST) begin
            st_next.active = 1'b0;
            if (req_ready && !(fetch_int && req.kind == CYC_FETCH)) begin
                st_next.active = 1'b1;
                st_next.cur    = req;
            end
        end
        // Read data captured at end of strobe
        if (st_reg.active && st_reg.phase == PH_STB_END && st_reg.cur.kind != CYC_WRITE) begin
            st_next.rd   = port0_in;
            st_next.rd_v = 1'b1;
        end
        // Strong pull-up timers per pin
        st_next.p3_prev = p3_latch;
        for (int i = 0; i < 4; i++) begin
            if (p3_latch[i] && !st_reg.p3_prev[i])
                st_next.p3_strong[2*i +: 2] = STRONG_PU_LOAD;            // [RQ2]
            else if (st_reg.p3_strong[2*i +: 2] != 2'h0)
                st_next.p3_strong[2*i +: 2] = st_reg.p3_strong[2*i +: 2] - 2'h1;
        end
    end

    // =====================================================
    // Registers
    // =====================================================
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg       <= '0;
            st_reg.first <= 1'b1;
            st_reg.p3_prev <= P3_UPPER_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================
    // Pin drive
    // =====================================================
    logic is_data;
    logic in_stb;
    logic ale_raw;
    assign is_data = st_reg.active && st_reg.cur.kind != CYC_FETCH;
    assign in_stb  = st_reg.active && st_reg.phase >= PH_STB_START && st_reg.phase <= PH_STB_END; // [RQ19]
    assign ale_raw = st_reg.phase <= PH_ALE_END && !(is_data);                // [RQ15]

    always_comb begin
        // Data slots already drop the pulse inside ale_raw
        ale = ale_raw && !power_control_register[PWR_ALE_OFF_BIT];            // [RQ16]
        // Program strobe: only for external fetches, high otherwise
        program_store_strobe_n  = !(in_stb && st_reg.cur.kind == CYC_FETCH); // [RQ11] [RQ12]
        program_store_strobe_oe = !st_reg.first;
        // Port0: low address during latch phase, then write data
        port0_out = (st_reg.phase <= PH_ALE_END) ? st_reg.cur.addr[7:0] : st_reg.cur.wdata; // [RQ18] [RQ14]
        port0_oe  = (st_reg.active && (st_reg.phase <= PH_ALE_END ||
                     st_reg.cur.kind == CYC_WRITE && in_stb)) ? 8'hFF : 8'h00;
        // Port2: address byte when active, else software latch
        if (st_reg.active && st_reg.cur.wide && st_reg.phase <= PH_ALE_END)
            {port2_upper_pins_out, port2_lower_pins_out} = st_reg.cur.addr[23:16]; // [RQ7]
        else if (st_reg.active)
            {port2_upper_pins_out, port2_lower_pins_out} = st_reg.cur.addr[15:8];  // [RQ6]
        else
            {port2_upper_pins_out, port2_lower_pins_out} = p2_latch;
        port2_oe      = st_reg.active ? 8'hFF : ~p2_latch;                 // [RQ5]
        port2_weak_pu = st_reg.active ? 8'h00 : p2_latch;
        // Port3 upper: strobes on pins 6 and 7 during data cycles
        port3_upper_pins_out = p3_latch;
        if (is_data) begin
            port3_upper_pins_out[2] = !(in_stb && st_reg.cur.kind == CYC_WRITE); // [RQ3]
            port3_upper_pins_out[3] = !(in_stb && st_reg.cur.kind == CYC_READ);  // [RQ4]
        end
        for (int i = 0; i < 4; i++) begin
            port3_weak_pu[i]       = port3_upper_pins_out[i];              // [RQ1]
            port3_upper_pins_oe[i] = !port3_upper_pins_out[i] ||
                                     (i >= 2 && is_data) || st_reg.p3_strong[2*i +: 2] != 2'h0; // [RQ2]
        end
        // Serial clock drives only low
        sclk_oe      = sclk_drive_low;                                       // [RQ17]
        sclk_weak_pu = !sclk_drive_low;
    end

    assign timer0_count_input = port3_upper_pins_in[0];
    assign timer1_count_input = port3_upper_pins_in[1];
    assign external_code_mode = st_reg.ext_mode;
    assign serial_download    = st_reg.dl_mode;
    assign rdata              = st_reg.rd;
    assign rdata_valid        = st_reg.rd_v;

    // =====================================================
    // Assertions
    // =====================================================
    property p_ale_skip;
        @(posedge core_clk) disable iff (!rstn) is_data |-> !ale;
    endproperty
    a_ale_skip: assert property (p_ale_skip) else $error("latch strobe in data slot"); // [RQ15]
    property p_ale_off;
        @(posedge core_clk) disable iff (!rstn) power_control_register[PWR_ALE_OFF_BIT] |-> !ale;
    endproperty
    a_ale_off: assert property (p_ale_off) else $error("latch strobe not disabled"); // [RQ16]
    property p_prog_data;
        @(posedge core_clk) disable iff (!rstn) is_data |-> program_store_strobe_n;
    endproperty
    a_prog_data: assert property (p_prog_data) else $error("program strobe on data"); // [RQ11]
    property p_prog_idle;
        @(posedge core_clk) disable iff (!rstn) !st_reg.active |-> program_store_strobe_n;
    endproperty
    a_prog_idle: assert property (p_prog_idle) else $error("program strobe while internal"); // [RQ12]
    property p_wr_len;
        @(posedge core_clk) disable iff (!rstn)
            $fell(port3_upper_pins_out[2]) |-> !port3_upper_pins_out[2] [*3] ##1 port3_upper_pins_out[2];
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe width"); // [RQ3]
    property p_rd_cap;
        @(posedge core_clk) disable iff (!rstn)
            $rose(port3_upper_pins_out[3]) |-> rdata_valid;
    endproperty
    a_rd_cap: assert property (p_rd_cap) else $error("read data not captured"); // [RQ4]
    property p_strong;
        @(posedge core_clk) disable iff (!rstn)
            $rose(p3_latch[0]) |=> port3_upper_pins_oe[0] [*2] ##1 !port3_upper_pins_oe[0] || !p3_latch[0];
    endproperty
    a_strong: assert property (p_strong) else $error("strong pull-up span"); // [RQ2]
    property p_order;
        @(posedge core_clk) disable iff (!rstn)
            $fell(program_store_strobe_n) |-> $past(ale || power_control_register[PWR_ALE_OFF_BIT], 2);
    endproperty
    a_order: assert property (p_order) else $error("strobe before address latch"); // [RQ19]
    property p_mode;
        @(posedge core_clk) disable iff (!rstn) !$past(st_reg.first) |-> $stable(external_code_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("code mode changed"); // [RQ9]
    c_fetch: cover property (@(posedge core_clk) disable iff (!rstn) $fell(program_store_strobe_n));
    c_write: cover property (@(posedge core_clk) disable iff (!rstn) $fell(port3_upper_pins_out[2]));
    c_read:  cover property (@(posedge core_clk) disable iff (!rstn) rdata_valid);
endmodule

// *** test/ext_mem_model.sv ***
`timescale 1ns/1ps
// ==========
// External memory behind a transparent address latch
// ==========
module ext_mem_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] port0_out,
    input  wire logic [7:0] port0_oe,
    input  wire logic [7:0] p2_out,
    input  wire logic [3:0] p3_out,
    input  wire logic [3:0] p3_oe,
    input  wire logic       ale,
    input  wire logic       prog_strobe_n,
    output logic [7:0]      port0_in
);
    logic [7:0]  mem[logic [15:0]];  // Bytes written so far
    logic [15:0] lat_reg = 16'h0000; // Address held across the strobe
    logic [15:0] keys[$];            // Address seen at each strobe start
    int          n_ale   = 0;        // Latch strobe pulses
    int          n_prog  = 0;        // Program strobe pulses
    logic [7:0]  last    = 8'h00;    // Previous bus level
    logic        ale_q   = 1'b0;
    logic        act_q   = 1'b0;
    wire logic   wr      = p3_oe[2] && !p3_out[2];
    wire logic   rd      = p3_oe[3] && !p3_out[3];
    wire logic   act     = wr || rd || !prog_strobe_n;
    // Drive only while enabled; a released bus churns so stale data never passes
    always @* begin
        if (!prog_strobe_n || rd) begin
            port0_in = mem.exists(lat_reg) ? mem[lat_reg] : lat_reg[7:0] ^ lat_reg[15:8] ^ 8'hA5;
        end else begin
            port0_in = ~last;
        end
    end
    // Latch follows the bus between strobes; counters are NBA to avoid races
    always @(posedge core_clk) begin
        last  <= port0_in;
        ale_q <= ale;
        act_q <= act;
        if (ale && !ale_q) n_ale <= n_ale + 1;
        if (!prog_strobe_n && !act_q) n_prog <= n_prog + 1;
        if (act && !act_q) keys.push_back(lat_reg);
        if (!act && port0_oe == 8'hFF) lat_reg <= {p2_out, port0_out};
        if (wr) mem[lat_reg] = port0_out;
    end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import ext_bus_pkg::*;
    // ==========
    // Stimulus, pins and counters
    // ==========
    logic       core_clk = 1'b0;
    logic       rstn     = 1'b0;
    req_s       req      = '0;
    logic [7:0] power_control_register = 8'h00, p2_latch = 8'hFF;
    logic [3:0] p3_latch = 4'hF, ext_low = 4'h0; // Outside pulls on port3
    logic       external_code_select = 1'b0, sclk_drive_low = 1'b0;
    logic       strap    = 1'b1;                 // Download strap resistor
    logic       xmode    = 1'b1;                 // Expected code mode
    logic       req_ready, rdata_valid, timer0_count_input, timer1_count_input, ale, program_store_strobe_n;
    logic       program_store_strobe_oe, external_code_mode, serial_download, sclk_oe, sclk_weak_pu;
    logic [7:0] rdata, port2_oe, port2_weak_pu, port0_out, port0_oe, port0_in, port2_in;
    logic [3:0] port3_upper_pins_out, port3_upper_pins_oe, port3_weak_pu, port2_lower_pins_out;
    logic [3:0] port2_upper_pins_out, port3_upper_pins_in;
    logic       program_store_strobe_in;
    logic [7:0] bmem[logic [15:0]];              // Expected memory contents
    int         n_mismatch = 0, samples_checked = 0, cycles = 0;
    // Pin levels from every party's drive
    assign port3_upper_pins_in = (port3_upper_pins_oe & port3_upper_pins_out) | (~port3_upper_pins_oe & ~ext_low);
    assign port2_in = ({port2_upper_pins_out, port2_lower_pins_out} & port2_oe) | ~port2_oe;
    assign program_store_strobe_in = program_store_strobe_oe ? program_store_strobe_n : strap;
    external_memory_bus_port dut_u (.core_clk, .rstn, .req, .req_ready, .rdata, .rdata_valid,
        .power_control_register, .p3_latch, .p2_latch, .port3_upper_pins_in, .port3_upper_pins_out,
        .port3_upper_pins_oe, .port3_weak_pu, .timer0_count_input, .timer1_count_input,
        .port2_lower_pins_out, .port2_upper_pins_out, .port2_oe, .port2_weak_pu, .port2_in, .port0_out,
        .port0_oe, .port0_in, .ale, .program_store_strobe_n, .program_store_strobe_oe,
        .program_store_strobe_in, .external_code_select, .external_code_mode, .serial_download,
        .sclk_drive_low, .sclk_oe, .sclk_weak_pu);
    ext_mem_model mem_u (.core_clk, .port0_out, .port0_oe, .p2_out({port2_upper_pins_out, port2_lower_pins_out}),
        .p3_out(port3_upper_pins_out), .p3_oe(port3_upper_pins_oe), .ale, .prog_strobe_n(program_store_strobe_n),
        .port0_in);
    always #10 core_clk = ~core_clk;
    // Hang guard, well above the few hundred cycles used
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ==========
    // Shared tasks
    // ==========
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_state(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: state %h expected %h", $time, got, exp);
        end
    endtask
    // Mode strap and download strap are caught at reset release
    task automatic do_reset(input logic sel, input logic pin);
        rstn <= 1'b0;
        external_code_select <= sel;
        strap <= pin;
        xmode = !sel;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        strap <= 1'b1;
        chk_state(16'({external_code_mode, serial_download}), 16'({!sel, !pin}));
    endtask
    // One request held until taken, then one six-cycle slot
    task automatic access(input cyc_e k, input logic [23:0] a, input logic w, input logic [7:0] d);
        int          na;
        int          np;
        int          t;
        logic        ext;
        logic [15:0] key;
        ext = !(k == CYC_FETCH && !xmode && a[15:0] <= INT_CODE_TOP);
        key = {(w && k != CYC_FETCH) ? a[23:16] : a[15:8], a[7:0]};
        req <= '{1'b1, k, a, d, w};
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (req_ready !== 1'b1 && t < 20);
        chk_state(16'(req_ready === 1'b1), 16'h0001);
        req.valid <= 1'b0;
        na = mem_u.n_ale;
        np = mem_u.n_prog;
        repeat (6) @(posedge core_clk);
        chk_state(16'(rdata_valid), 16'(ext && k != CYC_WRITE));
        chk_state(16'(mem_u.n_prog - np), 16'(ext && k == CYC_FETCH));
        if (!ext) return;
        chk_state(16'(mem_u.n_ale - na), 16'(k == CYC_FETCH && !power_control_register[4]));
        chk_state(16'(mem_u.keys.size()), 16'h0001);
        chk_state(mem_u.keys.pop_front(), key);
        if (k == CYC_WRITE) bmem[key] = d;
        else chk_data(rdata, bmem.exists(key) ? bmem[key] : key[7:0] ^ key[15:8] ^ 8'hA5);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========
    // Tests
    // ==========
    initial begin
        cyc_e        k;
        logic [23:0] a;
        int          n;
        void'($urandom(32'h888C));
        do_reset(1'b0, 1'b1);
        // Mixed traffic on a small address set so reads meet earlier writes
        for (int i = 0; i < 40; i++) begin
            k = cyc_e'($urandom_range(2));
            a = 24'($urandom) & 24'h810107;
            power_control_register <= (i >= 30) ? 8'h10 : 8'h00;
            access(k, a, (k != CYC_FETCH) && $urandom_range(1), 8'($urandom));
        end
        $display("test bus done");
        // Rising latch bit gets a short strong drive, then weak pull-up only
        p3_latch <= 4'hE;
        repeat (3) @(posedge core_clk);
        p3_latch <= 4'hF;
        n = 0;
        repeat (6) begin
            @(posedge core_clk);
            #1 n += int'(port3_upper_pins_oe[0] & port3_upper_pins_out[0]);
        end
        chk_state(16'(n), 16'h0002);
        ext_low <= 4'h1;
        p2_latch <= 8'($urandom);
        sclk_drive_low <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk_state(16'({port3_upper_pins_oe[0], port3_weak_pu[0], timer0_count_input}), 16'h0002);
        chk_state({port2_oe, port2_weak_pu}, {~p2_latch, p2_latch});
        chk_state(16'({sclk_oe, sclk_weak_pu}), 16'h0002);
        sclk_drive_low <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk_state(16'({sclk_oe, sclk_weak_pu}), 16'h0001);
        $display("test pins done");
        // Internal mode: top of internal space stays off the bus, next byte goes out
        do_reset(1'b1, 1'b0);
        access(CYC_FETCH, 24'h001FFF, 1'b0, 8'h00);
        chk_state(16'(program_store_strobe_n), 16'h0001);
        access(CYC_FETCH, 24'h002000, 1'b0, 8'h00);
        $display("test internal done");
        tally_and_finish();
    end
endmodule
